// [hw/bcwd_top.sv]
// Boot configuration word decoder: captures both boot words once after reset,
// decodes them into static settings, and exposes raw and decoded state on Avalon-MM.
// Assumes the word inputs and code-protect strap are asynchronous but static after power-up.
//
// Functional notes
// - Protect field is complement of protected page count
// - Block flash writes below decoded page boundary
// - Pair select codes route debugger pin pair
// - Scan enable bit seeds runtime config register
// - Debugger enabled when upper bit zero; protect forces
// - Clock switch and monitor field decode
// - Peripheral bus divides system clock by 1/2/4/8
// - Clock output active only with posc off/external
// - Primary oscillator mode decode
// - Two-speed start-up follows switchover bit
// - Secondary oscillator follows its enable bit
// - Initial source codes 111,110,101,100,000
// - Initial source codes 011,010,001
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

module bcwd_top
    import bcwd_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Nonvolatile words and strap
    input wire logic [31:0] boot_config_word0_i,
    input wire logic [31:0] boot_config_word1_i,
    input wire logic code_protect_i,
    // Flash write check
    input wire logic flash_wr_req_i,
    input wire logic [31:0] flash_wr_addr_i,
    output logic flash_wr_block_o,
    // Decoded settings
    output bcwd_settings_t settings_o,
    output logic settings_valid_o,
    output logic scan_port_enable_o,
    output logic periph_bus_tick_o,
    output logic oscillator_out_pin_en_o,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // Input synchronisers; stage one feeds stage two only
    logic [31:0] w0_meta_q, w0_sync_q, w1_meta_q, w1_sync_q;
    logic cp_meta_q, cp_sync_q;

    always_ff @(posedge clock_i) begin
        w0_meta_q <= boot_config_word0_i;
        w0_sync_q <= w0_meta_q;
        w1_meta_q <= boot_config_word1_i;
        w1_sync_q <= w1_meta_q;
        cp_meta_q <= code_protect_i;
        cp_sync_q <= cp_meta_q;
    end

    // One-time capture after the synchronisers have settled
    logic [1:0] settle_q;
    logic captured_q;
    logic [31:0] word0_q, word1_q;
    logic cp_q;
    wire capture_now = !captured_q && (settle_q == BCWD_SETTLE_CYCLES);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            settle_q <= '0;
            captured_q <= 1'b0;
            word0_q <= BCWD_WORD_RESET;
            word1_q <= BCWD_WORD_RESET;
            cp_q <= 1'b0;
        end else if (capture_now) begin
            captured_q <= 1'b1;
            word0_q <= w0_sync_q;
            word1_q <= w1_sync_q;
            cp_q <= cp_sync_q;
        end else if (!captured_q) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // Word 0 decode
    wire [7:0] prot_code = word0_q[BCWD_W0_PROT_LSB +: 8];
    wire prot_reserved = prot_code < BCWD_PROT_LAST_CODE;
    // Reserved codes clamp to the largest defined boundary so protection never shrinks
    wire [7:0] prot_pages = prot_reserved ? ~BCWD_PROT_LAST_CODE : ~prot_code;
    wire [31:0] prot_limit = BCWD_FLASH_BASE + {12'h000, prot_pages, 12'h000};
    wire [1:0] pair_code = word0_q[BCWD_W0_PAIR_LSB +: 2];
    wire [3:0] pair_onehot = 4'h1 << (2'h3 - pair_code);
    wire [1:0] dbg_field = cp_q ? 2'h3 : word0_q[BCWD_W0_DBG_LSB +: 2];
    wire rsv0_bad = word0_q[BCWD_W0_RSV_LSB +: 7] != BCWD_W0_RSV_ONES;

    // Word 1 decode
    wire [1:0] csm_code = word1_q[BCWD_W1_CSM_LSB +: 2];
    wire [1:0] pbdiv_code = word1_q[BCWD_W1_PBDIV_LSB +: 2];
    wire clkout_n = word1_q[BCWD_W1_CLKOUT_N_BIT];
    bcwd_posc_t posc_mode;
    bcwd_osc_t osc_sel;
    assign posc_mode = bcwd_posc_t'(word1_q[BCWD_W1_POSC_LSB +: 2]);
    assign osc_sel = bcwd_osc_t'(word1_q[BCWD_W1_OSC_LSB +: 3]);
    wire clkout_active = !clkout_n && (posc_mode == BCWD_POSC_OFF || posc_mode == BCWD_POSC_EXT);
    wire posc_conflict = (posc_mode == BCWD_POSC_OFF) && (osc_sel == BCWD_OSC_POSC);
    wire rsv1_bad = !word1_q[BCWD_W1_RSV11_BIT] || !word1_q[BCWD_W1_RSV6_BIT] ||
                    (word1_q[BCWD_W1_RSV43_LSB +: 2] != BCWD_W1_RSV43_ONES);

    bcwd_settings_t settings_d;
    always_comb begin
        settings_d = '0;
        settings_d.protect_pages = prot_pages;
        settings_d.protect_reserved = prot_reserved;
        settings_d.debug_pair_onehot = pair_onehot;
        settings_d.scan_port_enable = word0_q[BCWD_W0_SCAN_BIT];
        settings_d.debugger_enable = !dbg_field[1];
        settings_d.clock_switch_enable = !csm_code[1];
        settings_d.clock_monitor_enable = csm_code == 2'h0;
        settings_d.periph_bus_divisor_default = pbdiv_code;
        settings_d.clock_output_active = clkout_active;
        settings_d.primary_osc_mode = posc_mode;
        settings_d.two_speed_startup = word1_q[BCWD_W1_TWOSPD_BIT];
        settings_d.secondary_osc_enable = word1_q[BCWD_W1_SOSC_BIT];
        settings_d.initial_osc_select = osc_sel;
        settings_d.posc_conflict = posc_conflict;
        settings_d.reserved_bits_bad = rsv0_bad || rsv1_bad;
    end

    // Settings register: changes only on the capture-following cycle
    logic settle_done_q;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            settings_o <= '0;
            settings_valid_o <= 1'b0;
            settle_done_q <= 1'b0;
        end else if (captured_q && !settle_done_q) begin
            settings_o <= settings_d;
            settings_valid_o <= 1'b1;
            settle_done_q <= 1'b1;
        end
    end

    // Flash write guard against the decoded boundary
    wire wr_in_protected = flash_wr_addr_i >= BCWD_FLASH_BASE && flash_wr_addr_i < prot_limit;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            flash_wr_block_o <= 1'b0;
        end else begin
            // Until the settings register loads, block all flash writes rather than trust stale words
            flash_wr_block_o <= flash_wr_req_i && (!settle_done_q || wr_in_protected);
        end
    end

    // Peripheral bus tick: system clock divided by 1, 2, 4 or 8
    logic [2:0] pb_cnt_q;
    logic [1:0] pbdiv_q;
    wire [2:0] pb_last = 3'((4'h1 << pbdiv_q) - 4'h1);
    wire pb_wrap = pb_cnt_q >= pb_last;

    always_ff @(posedge clock_i) begin
        if (reset_i || !settle_done_q) begin
            pb_cnt_q <= '0;
            periph_bus_tick_o <= 1'b0;
        end else begin
            pb_cnt_q <= pb_wrap ? 3'h0 : pb_cnt_q + 3'h1;
            periph_bus_tick_o <= pb_wrap;
        end
    end

    // Runtime config: scan enable seeded by the boot word, software may change it
    logic scan_q;
    wire [4:0] addr = avs_address;
    wire req = avs_read || avs_write;
    wire req_take = req && !avs_waitrequest;
    wire sel_word0 = addr == BCWD_OFS_WORD0;
    wire sel_word1 = addr == BCWD_OFS_WORD1;
    wire sel_status = addr == BCWD_OFS_STATUS;
    wire sel_runcfg = addr == BCWD_OFS_RUNCFG;
    wire sel_limit = addr == BCWD_OFS_LIMIT;
    wire runcfg_wr = req_take && avs_write && sel_runcfg && avs_byteenable[0];

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            scan_q <= 1'b0;
            pbdiv_q <= 2'h0;
            scan_port_enable_o <= 1'b0;
            oscillator_out_pin_en_o <= 1'b0;
        end else begin
            if (captured_q && !settle_done_q) begin
                scan_q <= settings_d.scan_port_enable;
                pbdiv_q <= pbdiv_code;
            end else if (runcfg_wr) begin
                scan_q <= avs_writedata[0];
            end
            scan_port_enable_o <= scan_q;
            oscillator_out_pin_en_o <= settings_o.clock_output_active && settings_valid_o;
        end
    end

    // Status word layout
    wire [31:0] status_word = {3'h0, settings_o.protect_pages, settings_o.initial_osc_select,
                               settings_o.primary_osc_mode, settings_o.periph_bus_divisor_default,
                               settings_o.debug_pair_onehot, settings_o.reserved_bits_bad,
                               settings_o.posc_conflict, settings_o.secondary_osc_enable,
                               settings_o.two_speed_startup, settings_o.clock_output_active,
                               settings_o.clock_monitor_enable, settings_o.clock_switch_enable,
                               settings_o.debugger_enable, settings_o.protect_reserved, settings_valid_o};

    wire [31:0] read_mux = sel_word0 ? word0_q :
                           sel_word1 ? word1_q :
                           sel_status ? status_word :
                           sel_runcfg ? {31'h0, scan_q} :
                           sel_limit ? prot_limit - 32'h1 :
                           32'h0;

    // One wait cycle per access; unmapped reads return zero, writes drop
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (req && avs_waitrequest && avs_read) begin
                avs_readdata <= read_mux;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_capture_holds: assert property (settle_done_q |=> $stable(settings_o))
        else $error("settings changed after capture");
    a_words_stable: assert property (captured_q |=> $stable(word0_q) && $stable(word1_q))
        else $error("captured word changed");
    a_prot_block: assert property (settle_done_q && flash_wr_req_i && flash_wr_addr_i == BCWD_FLASH_BASE
                                   && prot_code != BCWD_PROT_OFF |=> flash_wr_block_o)
        else $error("protected page write not blocked");
    a_prot_off: assert property (settle_done_q && prot_code == BCWD_PROT_OFF |=> !flash_wr_block_o)
        else $error("write blocked with protection off");
    a_prot_reserved: assert property (settings_valid_o && settings_o.protect_reserved
                                      |-> settings_o.protect_pages == 8'h40)
        else $error("reserved code not clamped");
    a_debug_force: assert property (settings_valid_o && cp_q |-> !settings_o.debugger_enable)
        else $error("debugger enabled under code protect");
    a_pair_map: assert property (settings_valid_o && pair_code == 2'h3
                                 |-> settings_o.debug_pair_onehot == 4'h1)
        else $error("pair one not selected");
    a_csm_decode: assert property (settings_valid_o && settings_o.clock_monitor_enable
                                   |-> settings_o.clock_switch_enable)
        else $error("monitor without switching");
    a_pb_period: assert property (periph_bus_tick_o && pbdiv_q == 2'h2 && settle_done_q
                                  |=> !periph_bus_tick_o [*3] ##1 periph_bus_tick_o)
        else $error("divide by four tick spacing wrong");
    a_clkout_gate: assert property (oscillator_out_pin_en_o |-> posc_mode == BCWD_POSC_OFF
                                  || posc_mode == BCWD_POSC_EXT)
        else $error("clock output with active crystal");
    a_scan_seed: assert property ($rose(settle_done_q) |-> scan_q == word0_q[BCWD_W0_SCAN_BIT])
        else $error("scan enable not seeded");
    a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_bus_release: assert property (!avs_waitrequest
                                    |=> avs_waitrequest)
        else $error("wait state skipped after answer");

    // Write protection decode and guard
    a_prot_count: assert property (settings_valid_o && !settings_o.protect_reserved
                                   |-> settings_o.protect_pages == ~prot_code)
        else $error("protect page count wrong");
    a_prot_above: assert property (settle_done_q && flash_wr_req_i && flash_wr_addr_i >= prot_limit
                                   |=> !flash_wr_block_o)
        else $error("write above boundary blocked");
    a_prot_below: assert property (settle_done_q && flash_wr_addr_i < BCWD_FLASH_BASE
                                   |=> !flash_wr_block_o)
        else $error("write below flash base blocked");
    a_prot_flag: assert property (settings_valid_o && prot_code >= BCWD_PROT_LAST_CODE
                                  |-> !settings_o.protect_reserved)
        else $error("defined code flagged reserved");

    // Debug and scan port settings
    a_pair_two: assert property (settings_valid_o && pair_code == 2'h2
                                 |-> settings_o.debug_pair_onehot == 4'h2)
        else $error("pair two not selected");
    a_pair_four: assert property (settings_valid_o && pair_code == 2'h0
                                  |-> settings_o.debug_pair_onehot == 4'h8)
        else $error("pair four not selected");
    a_scan_copy: assert property (settings_valid_o
                                  |-> settings_o.scan_port_enable == word0_q[BCWD_W0_SCAN_BIT])
        else $error("scan enable setting wrong");
    a_debug_open: assert property (settings_valid_o && !cp_q && !word0_q[BCWD_W0_DBG_LSB + 1]
                                   |-> settings_o.debugger_enable)
        else $error("debugger not enabled");

    // Clock settings
    a_switch_off: assert property (settings_valid_o && csm_code[1]
                                   |-> !settings_o.clock_switch_enable && !settings_o.clock_monitor_enable)
        else $error("switching not disabled");
    a_switch_only: assert property (settings_valid_o && csm_code == 2'h1
                                    |-> settings_o.clock_switch_enable && !settings_o.clock_monitor_enable)
        else $error("switch only decode wrong");
    a_pb_div1: assert property (periph_bus_tick_o && pbdiv_q == 2'h0 && settle_done_q
                                |=> periph_bus_tick_o)
        else $error("divide by one tick missing");
    a_pb_div2: assert property (periph_bus_tick_o && pbdiv_q == 2'h1 && settle_done_q
                                |=> !periph_bus_tick_o ##1 periph_bus_tick_o)
        else $error("divide by two tick spacing wrong");
    a_pb_div8: assert property (periph_bus_tick_o && pbdiv_q == 2'h3 && settle_done_q
                                |=> !periph_bus_tick_o [*7] ##1 periph_bus_tick_o)
        else $error("divide by eight tick spacing wrong");
    a_clkout_off: assert property (settings_valid_o && clkout_n
                                   |=> !oscillator_out_pin_en_o)
        else $error("clock output with enable bit clear");
    a_posc_off: assert property (settings_valid_o && word1_q[BCWD_W1_POSC_LSB +: 2] == 2'h3
                                 |-> settings_o.primary_osc_mode == BCWD_POSC_OFF)
        else $error("primary oscillator off decode wrong");
    a_posc_fast: assert property (settings_valid_o && word1_q[BCWD_W1_POSC_LSB +: 2] == 2'h2
                                  |-> settings_o.primary_osc_mode == BCWD_POSC_HS)
        else $error("high speed crystal decode wrong");
    a_two_speed: assert property (settings_valid_o
                                  |-> settings_o.two_speed_startup == word1_q[BCWD_W1_TWOSPD_BIT])
        else $error("two speed start-up setting wrong");
    a_sosc_enable: assert property (settings_valid_o
                                    |-> settings_o.secondary_osc_enable == word1_q[BCWD_W1_SOSC_BIT])
        else $error("secondary oscillator setting wrong");
    a_osc_low_power: assert property (settings_valid_o && word1_q[BCWD_W1_OSC_LSB +: 3] == 3'h5
                                      |-> settings_o.initial_osc_select == BCWD_OSC_LOW_POWER_RC)
        else $error("low power source decode wrong");
    a_osc_primary: assert property (settings_valid_o && word1_q[BCWD_W1_OSC_LSB +: 3] == 3'h2
                                    |-> settings_o.initial_osc_select == BCWD_OSC_POSC)
        else $error("direct primary source decode wrong");

    // Settings stay put once valid
    a_valid_holds: assert property (settings_valid_o
                                    |=> settings_valid_o)
        else $error("settings valid dropped without reset");

    c_capture: cover property ($rose(settings_valid_o));
    c_block: cover property (flash_wr_block_o);
    c_read_status: cover property (avs_read && !avs_waitrequest && sel_status);
    c_scan_write: cover property (runcfg_wr);
    c_posc_conflict: cover property (settings_valid_o && settings_o.posc_conflict);

endmodule : bcwd_top

// [inc/bcwd_pkg.sv]
// Boot configuration word decoder: shared constants, field layouts and types.
// Assumes both words come from nonvolatile storage and stay stable after reset.
package bcwd_pkg;

    // Register byte offsets on the register bus
    localparam logic [4:0] BCWD_OFS_WORD0 = 5'h00;
    localparam logic [4:0] BCWD_OFS_WORD1 = 5'h04;
    localparam logic [4:0] BCWD_OFS_STATUS = 5'h08;
    localparam logic [4:0] BCWD_OFS_RUNCFG = 5'h0c;
    localparam logic [4:0] BCWD_OFS_LIMIT = 5'h10;

    // Word 0 field positions
    localparam int BCWD_W0_PROT_LSB = 12;
    localparam int BCWD_W0_RSV_LSB = 5;
    localparam int BCWD_W0_PAIR_LSB = 3;
    localparam int BCWD_W0_SCAN_BIT = 2;
    localparam int BCWD_W0_DBG_LSB = 0;

    // Word 1 field positions
    localparam int BCWD_W1_CSM_LSB = 14;
    localparam int BCWD_W1_PBDIV_LSB = 12;
    localparam int BCWD_W1_RSV11_BIT = 11;
    localparam int BCWD_W1_CLKOUT_N_BIT = 10;
    localparam int BCWD_W1_POSC_LSB = 8;
    localparam int BCWD_W1_TWOSPD_BIT = 7;
    localparam int BCWD_W1_RSV6_BIT = 6;
    localparam int BCWD_W1_SOSC_BIT = 5;
    localparam int BCWD_W1_RSV43_LSB = 3;
    localparam int BCWD_W1_OSC_LSB = 0;

    // Reserved field contents expected from the programmer
    localparam logic [6:0] BCWD_W0_RSV_ONES = 7'h7f;
    localparam logic [1:0] BCWD_W1_RSV43_ONES = 2'h3;

    // Write protection geometry
    localparam logic [7:0] BCWD_PROT_OFF = 8'hff;
    localparam logic [7:0] BCWD_PROT_LAST_CODE = 8'hbf;
    localparam logic [31:0] BCWD_FLASH_BASE = 32'hbd00_0000;
    localparam int BCWD_PAGE_SHIFT = 12;

    // Cycles to let the input synchronisers settle before the one-time capture
    localparam logic [1:0] BCWD_SETTLE_CYCLES = 2'h3;

    // Reset value of a raw word before its capture
    localparam logic [31:0] BCWD_WORD_RESET = 32'hffff_ffff;

    typedef enum logic [1:0] {BCWD_POSC_EXT, BCWD_POSC_XT, BCWD_POSC_HS, BCWD_POSC_OFF} bcwd_posc_t;
    typedef enum logic [2:0] {BCWD_OSC_FAST_RC, BCWD_OSC_FAST_RC_DIV_PLL, BCWD_OSC_POSC, BCWD_OSC_POSC_PLL,
                              BCWD_OSC_SOSC, BCWD_OSC_LOW_POWER_RC, BCWD_OSC_FAST_RC_DIV16,
                              BCWD_OSC_FAST_RC_DIV} bcwd_osc_t;

    typedef struct packed {
        logic [7:0] protect_pages;
        logic protect_reserved;
        logic [3:0] debug_pair_onehot;
        logic scan_port_enable;
        logic debugger_enable;
        logic clock_switch_enable;
        logic clock_monitor_enable;
        logic [1:0] periph_bus_divisor_default;
        logic clock_output_active;
        bcwd_posc_t primary_osc_mode;
        logic two_speed_startup;
        logic secondary_osc_enable;
        bcwd_osc_t initial_osc_select;
        logic posc_conflict;
        logic reserved_bits_bad;
    } bcwd_settings_t;

endpackage : bcwd_pkg

// [bench/bcwd_top_tb_top.sv]
// Self-checking bench for the boot configuration word decoder.
// Assumes a 40 MHz clock; the bench drives every port itself.
`timescale 1ns/1ps

module bcwd_top_tb_top;
    import bcwd_pkg::*;

    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] w0 = 32'hffff_ffff;
    logic [31:0] w1 = 32'hffff_ffff;
    logic cp = 1'b0;
    logic wr_req = 1'b0;
    logic [31:0] wr_addr = 32'h0;
    logic blk;
    bcwd_settings_t set_o;
    logic valid_o, scan_o, tick_o, pin_o;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int errors = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'd21;

    bcwd_top DUT (.clock_i(clock_i), .reset_i(reset_i), .boot_config_word0_i(w0), .boot_config_word1_i(w1),
        .code_protect_i(cp), .flash_wr_req_i(wr_req), .flash_wr_addr_i(wr_addr), .flash_wr_block_o(blk),
        .settings_o(set_o), .settings_valid_o(valid_o), .scan_port_enable_o(scan_o),
        .periph_bus_tick_o(tick_o), .oscillator_out_pin_en_o(pin_o), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low; only the watchdog bounds the wait
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        do begin
            @(posedge clock_i);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Let an edge pass so back-to-back calls never drive a strobe twice in one step
        @(posedge clock_i);
    endtask : bus

    task automatic flash(input logic [31:0] a, input logic exp);
        wr_req <= 1'b1;
        wr_addr <= a;
        @(posedge clock_i);
        wr_req <= 1'b0;
        @(posedge clock_i);
        chk({31'h0, blk}, {31'h0, exp}, "flash guard");
    endtask : flash

    logic [7:0] prot_tab [8] = '{8'hff, 8'hfe, 8'hef, 8'hbf, 8'hbe, 8'h00, 8'hf0, 8'hc3};

    initial begin
        bcwd_settings_t e;
        logic [31:0] q, lim, r, raw0;
        int pages, ticks, n;
        for (int i = 0; i < 8; i++) begin
            reset_i <= 1'b1;
            r = rnd();
            raw0 = {r[31:20], prot_tab[i], (i == 5) ? 7'h15 : 7'h7f, i[1:0], r[2:0]};
            w0 <= raw0;
            r = rnd();
            w1 <= {r[31:16], i[1:0], i[2:1], i != 6, r[10], i[1:0] ^ {i[2], 1'b1}, r[7], 1'b1, r[5],
                2'h3, i[2:0]};
            cp <= r[0];
            repeat (10) @(posedge clock_i);
            reset_i <= 1'b0;
            flash(BCWD_FLASH_BASE, 1'b1);
            n = 0;
            do begin
                @(posedge clock_i);
                n++;
            end while (valid_o !== 1'b1 && n < 20);
            pages = (prot_tab[i] < 8'hbf) ? 64 : 255 - prot_tab[i];
            e.protect_pages = 8'(pages);
            e.protect_reserved = prot_tab[i] < 8'hbf;
            e.debug_pair_onehot = 4'h1 << (3 - w0[4:3]);
            e.scan_port_enable = w0[2];
            e.debugger_enable = !(w0[1] | cp);
            e.clock_switch_enable = !w1[15];
            e.clock_monitor_enable = w1[15:14] == 2'h0;
            e.periph_bus_divisor_default = w1[13:12];
            e.clock_output_active = !w1[10] && (w1[9:8] == 2'h3 || w1[9:8] == 2'h0);
            e.primary_osc_mode = bcwd_posc_t'(w1[9:8]);
            e.two_speed_startup = w1[7];
            e.secondary_osc_enable = w1[5];
            e.initial_osc_select = bcwd_osc_t'(w1[2:0]);
            e.posc_conflict = w1[2:0] == 3'h2 && w1[9:8] == 2'h3;
            e.reserved_bits_bad = w0[11:5] != 7'h7f || !w1[11] || !w1[6] || w1[4:3] != 2'h3;
            // Inputs move after capture; decoded state must not follow
            w0 <= rnd();
            w1 <= rnd();
            cp <= !cp;
            chk(32'(set_o), 32'(e), "settings");
            ticks = 0;
            repeat (16) begin
                @(posedge clock_i);
                ticks += (tick_o === 1'b1);
            end
            chk(ticks, 16 >> e.periph_bus_divisor_default, "bus tick count");
            chk({31'h0, pin_o}, {31'h0, e.clock_output_active}, "clock out pin");
            chk({31'h0, scan_o}, {31'h0, e.scan_port_enable}, "scan seed");
            lim = 32'hbd00_0000 + 32'(pages) * 32'h1000;
            bus(1'b0, BCWD_OFS_LIMIT, 32'h0, q);
            chk(q, lim - 32'h1, "limit reg");
            if (pages > 0) flash(lim - 32'h1, 1'b1);
            flash(lim, 1'b0);
            flash(32'hbcff_fffc, 1'b0);
            bus(1'b0, BCWD_OFS_STATUS, 32'h0, q);
            chk(q, {3'h0, e.protect_pages, e.initial_osc_select, e.primary_osc_mode, e.periph_bus_divisor_default,
                e.debug_pair_onehot, e.reserved_bits_bad, e.posc_conflict, e.secondary_osc_enable,
                e.two_speed_startup, e.clock_output_active, e.clock_monitor_enable, e.clock_switch_enable,
                e.debugger_enable, e.protect_reserved, 1'b1}, "status");
            bus(1'b1, BCWD_OFS_RUNCFG, {31'h0, !e.scan_port_enable}, q);
            bus(1'b0, BCWD_OFS_RUNCFG, 32'h0, q);
            chk({31'h0, q[0]}, {31'h0, !e.scan_port_enable}, "runcfg readback");
            repeat (2) @(posedge clock_i);
            chk({31'h0, scan_o}, {31'h0, !e.scan_port_enable}, "scan follows runcfg");
            bus(1'b1, BCWD_OFS_WORD0, 32'h0, q);
            bus(1'b0, BCWD_OFS_WORD0, 32'h0, q);
            chk(q, raw0, "word0 readback");
            bus(1'b0, 5'h14, 32'h0, q);
            chk(q, 32'h0, "unmapped read");
            chk(32'(set_o), 32'(e), "settings held");
            $display("Test %0d done", i);
        end
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : bcwd_top_tb_top
